// File: owb_dev.sv
// Purpose: device end: receives frames, stores level, acknowledges
// Assumes: wire idles high through the host's pull-up
// Notes: bit rate learned per bit
// Behaviour
// - first byte must equal address 0x72
// - second byte: ack flag, two zero bits, level
// - bytes shift in MSB first
// - host holds line high 2 us before bytes
// - first falling edge accepted without start interval
// - 2 us high after last bit closes byte
// - one if high>=2x low, zero if reverse
// - bit measured falling edge to falling edge
// - acknowledge only for good, requested, matching frame
// - after validity delay pull low, at most 512 us
// - host holds low, releases, samples for zero
// - host waits for acknowledge end before next frame
// - acknowledge driver is open-drain, low only
// - only open-drain hosts request acknowledge
// - level defaults to 31, power reset restores
// - low beyond 2.5 ms means shutdown
// - works from 1.7 to 160 kbit/s
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module owb_dev #(
    parameter int CNT_W = 16,
    parameter int SD_CYC = owb_pkg::SHUTDOWN_CYC,
    parameter int ACK_CYC = owb_pkg::ACK_MAX_CYC,
    parameter int VAL_CYC = owb_pkg::ACK_VALID_CYC
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    owb_link_if.device_end LINK,
    output logic [owb_pkg::LEVEL_W-1:0] LEVEL_OUT,
    output logic SHUTDOWN_OUT,
    output logic FRAME_OK_OUT,
    output logic FRAME_BAD_OUT
);
    import owb_pkg::*;

    localparam int SD_W = $clog2(SD_CYC + 1);
    localparam logic [CNT_W-1:0] EOS_C = CNT_W'(EOS_CYC);
    localparam logic [CNT_W-1:0] VAL_LAST = CNT_W'(VAL_CYC - 1);
    localparam logic [CNT_W-1:0] ACK_LAST = CNT_W'(ACK_CYC - 1);
    localparam logic [SD_W-1:0] SD_C = SD_W'(SD_CYC);

    logic line_meta_q;
    logic line_q;
    logic line_prev_q;
    logic fall;
    logic rise;
    owb_dev_state_t st_q;
    logic [CNT_W-1:0] low_cnt_q;
    logic [CNT_W-1:0] high_cnt_q;
    logic [CNT_W:0] period_q;
    logic [CNT_W-1:0] tmr_q;
    logic [SD_W-1:0] sd_cnt_q;
    logic [BYTE_W-1:0] shift_q;
    logic [BYTE_W-1:0] addr_q;
    logic [3:0] bit_cnt_q;
    logic byte_idx_q;
    logic err_q;
    logic [1:0] bit_now;
    logic last_bit;
    logic [BYTE_W-1:0] closed_byte;
    logic byte_close;
    logic frame_good;
    logic [LEVEL_W-1:0] level_q;
    logic shutdown_q;
    logic ok_q;
    logic bad_q;
    logic ack_oe_q;

    // returns {valid, value}; neither ratio met means a bad bit
    function automatic logic [1:0] bit_decide(input logic [CNT_W-1:0] lo,
                                              input logic [CNT_W-1:0] hi);
        logic one;
        logic zero;
        one = ({1'b0, hi} >= {lo, 1'b0});
        zero = ({1'b0, lo} >= {hi, 1'b0});
        bit_decide = {one | zero, one};
    endfunction

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (&v) ? v : v + 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // line synchroniser and edges
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            line_meta_q <= 1'b1;
            line_q <= 1'b1;
            line_prev_q <= 1'b1;
        end else begin
            line_meta_q <= LINK.ctrl_line;
            line_q <= line_meta_q;
            line_prev_q <= line_q;
        end
    end

    assign fall = line_prev_q & ~line_q;
    assign rise = ~line_prev_q & line_q;

    ////////////////////////////////////////////////////////////////////////
    // bit decisions
    assign bit_now = bit_decide(low_cnt_q, high_cnt_q);
    // last bit's high merges into end-of-stream: judge low vs last period
    assign last_bit = ({low_cnt_q, 1'b0} < period_q);
    assign closed_byte = {shift_q[BYTE_W-2:0], last_bit};
    assign byte_close = (st_q == D_HIGH) && (bit_cnt_q >= 4'h7)
                        && (high_cnt_q >= EOS_C);
    assign frame_good = !err_q && (bit_cnt_q == 4'h7) && (addr_q == DEV_ADDR)
                        && !closed_byte[SUB_HI_POS] && !closed_byte[SUB_LO_POS];

    ////////////////////////////////////////////////////////////////////////
    // receive and acknowledge sequencer
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN || shutdown_q) begin
            st_q <= D_IDLE;
            low_cnt_q <= '0;
            high_cnt_q <= '0;
            period_q <= '0;
            tmr_q <= '0;
            shift_q <= '0;
            addr_q <= '0;
            bit_cnt_q <= '0;
            byte_idx_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            case (st_q)
                D_IDLE: begin
                    if (fall) begin
                        st_q <= D_LOW;
                        low_cnt_q <= CNT_W'(1);
                        bit_cnt_q <= '0;
                        byte_idx_q <= 1'b0;
                        err_q <= 1'b0;
                    end
                end
                D_LOW: begin
                    low_cnt_q <= sat_inc(low_cnt_q);
                    if (rise) begin
                        st_q <= D_HIGH;
                        high_cnt_q <= CNT_W'(1);
                    end
                end
                D_HIGH: begin
                    high_cnt_q <= sat_inc(high_cnt_q);
                    if (byte_close) begin
                        bit_cnt_q <= '0;
                        tmr_q <= '0;
                        if (!byte_idx_q) begin
                            addr_q <= closed_byte;
                            err_q <= err_q | (bit_cnt_q != 4'h7);
                            st_q <= D_GAP;
                        end else if (frame_good && closed_byte[ACK_REQ_POS]) begin
                            st_q <= D_AWAIT;
                        end else begin
                            st_q <= D_IDLE;
                        end
                    end else if (fall) begin
                        shift_q <= {shift_q[BYTE_W-2:0], bit_now[0]};
                        err_q <= err_q | ~bit_now[1];
                        if (bit_cnt_q != 4'hf) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        period_q <= {1'b0, low_cnt_q} + {1'b0, high_cnt_q};
                        low_cnt_q <= CNT_W'(1);
                        st_q <= D_LOW;
                    end else if (&high_cnt_q) begin
                        st_q <= D_IDLE;
                    end
                end
                D_GAP: begin
                    tmr_q <= sat_inc(tmr_q);
                    if (fall) begin
                        st_q <= D_LOW;
                        low_cnt_q <= CNT_W'(1);
                        byte_idx_q <= 1'b1;
                    end else if (&tmr_q) begin
                        st_q <= D_IDLE;
                    end
                end
                D_AWAIT: begin
                    tmr_q <= sat_inc(tmr_q);
                    if (fall) begin
                        st_q <= D_ADLY;
                        tmr_q <= '0;
                    end else if (&tmr_q) begin
                        st_q <= D_IDLE;
                    end
                end
                D_ADLY: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_q == VAL_LAST) begin
                        st_q <= D_ADRV;
                        tmr_q <= '0;
                    end
                end
                D_ADRV: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_q == ACK_LAST) begin
                        st_q <= D_AEND;
                    end
                end
                D_AEND: begin
                    if (line_q) begin
                        st_q <= D_IDLE;
                    end
                end
                default: begin
                    st_q <= D_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // acknowledge driver, pull-down only
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN || shutdown_q) begin
            ack_oe_q <= 1'b0;
        end else begin
            ack_oe_q <= ((st_q == D_ADLY) && (tmr_q == VAL_LAST))
                        || ((st_q == D_ADRV) && (tmr_q != ACK_LAST));
        end
    end

    assign LINK.dev_drv_o = 1'b0;
    assign LINK.dev_drv_oe = ack_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // stored level and frame result pulses
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN || shutdown_q) begin
            level_q <= LEVEL_DEFAULT;
            ok_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            ok_q <= byte_close && byte_idx_q && frame_good;
            bad_q <= byte_close && byte_idx_q && !frame_good;
            if (byte_close && byte_idx_q && frame_good) begin
                level_q <= closed_byte[LEVEL_MSB:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shutdown after a long low; the own acknowledge is far shorter
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            sd_cnt_q <= '0;
            shutdown_q <= 1'b0;
        end else if (line_q) begin
            sd_cnt_q <= '0;
            shutdown_q <= 1'b0;
        end else begin
            if (sd_cnt_q != SD_C) begin
                sd_cnt_q <= sd_cnt_q + 1'b1;
            end
            shutdown_q <= shutdown_q | (sd_cnt_q == SD_C);
        end
    end

    assign LEVEL_OUT = level_q;
    assign SHUTDOWN_OUT = shutdown_q;
    assign FRAME_OK_OUT = ok_q;
    assign FRAME_BAD_OUT = bad_q;
endmodule
`default_nettype wire

// File: owb_pkg.sv
// Purpose: shared constants and state types of the link
// Assumes: 40 MHz system clock on both ends
// Notes: times in ns, counts in cycles
package owb_pkg;
    localparam int CLK_NS = 25;
    localparam int T_START_NS = 2000;
    localparam int END_OF_STREAM_INTERVAL_NS = 2000;
    localparam int T_ACK_MAX_NS = 512000;
    localparam int T_SHUTDOWN_NS = 2500000;
    localparam int T_ACK_VALID_NS = 8000;
    localparam int T_HOST_HOLD_NS = 16000;
    localparam int T_BIT_UNIT_NS = 2000;
    // least times round up, longest times round down
    localparam int START_CYC = (T_START_NS + CLK_NS - 1) / CLK_NS;
    localparam int EOS_CYC = (END_OF_STREAM_INTERVAL_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACK_MAX_CYC = T_ACK_MAX_NS / CLK_NS;
    localparam int SHUTDOWN_CYC = T_SHUTDOWN_NS / CLK_NS;
    localparam int ACK_VALID_CYC = (T_ACK_VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOST_HOLD_CYC = (T_HOST_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int BIT_UNIT_CYC = (T_BIT_UNIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_CYC = 4;
    localparam int BYTE_W = 8;
    localparam int LEVEL_W = 5;
    localparam logic [7:0] DEV_ADDR = 8'h72;
    localparam logic [4:0] LEVEL_DEFAULT = 5'h1f;
    localparam int ACK_REQ_POS = 7;
    localparam int SUB_HI_POS = 6;
    localparam int SUB_LO_POS = 5;
    localparam int LEVEL_MSB = 4;
    // host register map
    localparam int APB_AW = 8;
    localparam logic [7:0] REG_CMD_OFS = 8'h00;
    localparam logic [7:0] REG_STAT_OFS = 8'h04;
    localparam int CMD_GO_POS = 8;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_ACK_POS = 1;
    localparam int STAT_DONE_POS = 2;

    typedef enum logic [2:0] {
        D_IDLE = 3'h0, D_LOW = 3'h1, D_HIGH = 3'h3, D_GAP = 3'h2,
        D_AWAIT = 3'h6, D_ADLY = 3'h7, D_ADRV = 3'h5, D_AEND = 3'h4
    } owb_dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0, H_START = 3'h1, H_LOW = 3'h3, H_HIGH = 3'h2,
        H_EOS = 3'h6, H_HOLD = 3'h7, H_SETTLE = 3'h5, H_WEND = 3'h4
    } owb_host_state_t;
endpackage

// File: owb_link_if.sv
// Purpose: the control wire between host and device, with its pull-up
// Assumes: both ends only ever pull the wire low
// Notes: wire level derived from the two enables
`timescale 1ns/100ps
`default_nettype none
interface owb_link_if;
    logic host_drv_o;
    logic host_drv_oe;
    logic dev_drv_o;
    logic dev_drv_oe;
    logic ctrl_line;

    // pull-up unless an enabled end pulls low
    assign ctrl_line = ~(host_drv_oe & ~host_drv_o) & ~(dev_drv_oe & ~dev_drv_o);

    modport device_end(input ctrl_line, output dev_drv_o, output dev_drv_oe);
    modport host_end(input ctrl_line, output host_drv_o, output host_drv_oe);
endinterface
`default_nettype wire

// File: owb_host.sv
// Purpose: host end: sends frames on order, checks acknowledge
// Assumes: open-drain drive, pull-up in the interface
// Notes: orders and status over APB
`timescale 1ns/100ps
`default_nettype none
module owb_host #(
    parameter int BIT_Q = owb_pkg::BIT_UNIT_CYC,
    parameter int HOLD_CYC = owb_pkg::HOST_HOLD_CYC
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [owb_pkg::APB_AW-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    owb_link_if.host_end LINK
);
    import owb_pkg::*;

    localparam int CW = 16;

    logic line_meta_q;
    logic line_q;
    logic acc;
    logic wr;
    logic go;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [BYTE_W-1:0] data_q;
    logic busy_q;
    logic ack_ok_q;
    logic done_q;
    owb_host_state_t st_q;
    logic [2*BYTE_W-1:0] shift_q;
    logic [3:0] bit_idx_q;
    logic [CW-1:0] cnt_q;
    logic drive_q;

    function automatic logic reg_hit(input logic [APB_AW-1:0] a);
        reg_hit = (a == REG_CMD_OFS) || (a == REG_STAT_OFS);
    endfunction

    // long phase is three units, short one unit: ratio 3 keeps 2x margin
    function automatic logic [CW-1:0] phase_last(input logic long_ph);
        phase_last = long_ph ? CW'(3 * BIT_Q - 1) : CW'(BIT_Q - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // line synchroniser
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            line_meta_q <= 1'b1;
            line_q <= 1'b1;
        end else begin
            line_meta_q <= LINK.ctrl_line;
            line_q <= line_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state
    assign acc = PSEL_IN & PENABLE_IN;
    assign wr = acc & pready_q & PWRITE_IN & (PADDR_IN == REG_CMD_OFS);
    assign go = wr & PWDATA_IN[CMD_GO_POS] & ~busy_q;

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~reg_hit(PADDR_IN);
            if (acc & ~pready_q & ~PWRITE_IN) begin
                if (PADDR_IN == REG_CMD_OFS) begin
                    prdata_q <= {24'h00_0000, data_q};
                end else if (PADDR_IN == REG_STAT_OFS) begin
                    prdata_q <= {29'h0000_0000, done_q, ack_ok_q, busy_q};
                end else begin
                    prdata_q <= 32'h0000_0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame sender; orders given while busy are ignored
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            st_q <= H_IDLE;
            data_q <= '0;
            shift_q <= '0;
            bit_idx_q <= '0;
            cnt_q <= '0;
            drive_q <= 1'b0;
            busy_q <= 1'b0;
            ack_ok_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            case (st_q)
                H_IDLE: begin
                    cnt_q <= '0;
                    if (go) begin
                        data_q <= PWDATA_IN[BYTE_W-1:0];
                        shift_q <= {DEV_ADDR, PWDATA_IN[BYTE_W-1:0]};
                        bit_idx_q <= '0;
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                        ack_ok_q <= 1'b0;
                        st_q <= H_START;
                    end
                end
                H_START: begin
                    if (cnt_q == CW'(START_CYC - 1)) begin
                        cnt_q <= '0;
                        drive_q <= 1'b1;
                        st_q <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (cnt_q == phase_last(~shift_q[2*BYTE_W-1])) begin
                        cnt_q <= '0;
                        drive_q <= 1'b0;
                        st_q <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (cnt_q == phase_last(shift_q[2*BYTE_W-1])) begin
                        cnt_q <= '0;
                        shift_q <= {shift_q[2*BYTE_W-2:0], 1'b0};
                        bit_idx_q <= bit_idx_q + 4'h1;
                        if (bit_idx_q[2:0] == 3'h7) begin
                            st_q <= H_EOS;
                        end else begin
                            drive_q <= 1'b1;
                            st_q <= H_LOW;
                        end
                    end
                end
                H_EOS: begin
                    if (cnt_q == CW'(EOS_CYC - 1)) begin
                        cnt_q <= '0;
                        if (bit_idx_q == 4'h8) begin
                            st_q <= H_START;
                        end else if (data_q[ACK_REQ_POS]) begin
                            drive_q <= 1'b1;
                            st_q <= H_HOLD;
                        end else begin
                            busy_q <= 1'b0;
                            done_q <= 1'b1;
                            st_q <= H_IDLE;
                        end
                    end
                end
                H_HOLD: begin
                    if (cnt_q == CW'(HOLD_CYC - 1)) begin
                        cnt_q <= '0;
                        drive_q <= 1'b0;
                        st_q <= H_SETTLE;
                    end
                end
                H_SETTLE: begin
                    if (cnt_q == CW'(SETTLE_CYC - 1)) begin
                        ack_ok_q <= ~line_q;
                        st_q <= H_WEND;
                    end
                end
                H_WEND: begin
                    if (line_q) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        st_q <= H_IDLE;
                    end
                end
                default: begin
                    drive_q <= 1'b0;
                    st_q <= H_IDLE;
                end
            endcase
        end
    end

    assign LINK.host_drv_o = 1'b0;
    assign LINK.host_drv_oe = drive_q;
    assign PRDATA_OUT = prdata_q;
    assign PREADY_OUT = pready_q;
    assign PSLVERR_OUT = pslverr_q;
endmodule
`default_nettype wire

// File: owb_link_chk.sv
// Purpose: wire-level checks between host and device
// Assumes: one clock, synchronous active-high reset
// Notes: counts in cycles
`timescale 1ns/100ps
`default_nettype none
module owb_link_chk #(
    parameter int BIT_Q = 80,
    parameter int HOLD_CYC = 640,
    parameter int VAL_CYC = 320,
    parameter int ACK_CYC = 20480
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic host_drv_o,
    input wire logic host_drv_oe,
    input wire logic dev_drv_o,
    input wire logic dev_drv_oe,
    input wire logic ctrl_line
);
    logic [15:0] hi_q;
    logic [15:0] lo_q;
    logic [15:0] ack_q;
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);
    ////////////////////////////////////////////////////////////////////////
    // saturates: a long idle never wraps to a short count
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN || !ctrl_line) begin
            hi_q <= 16'h0000;
        end else if (hi_q != 16'hffff) begin
            hi_q <= hi_q + 16'h0001;
        end
    end
    always_ff @(posedge SYS_CLK_IN) begin
        lo_q <= (RST_IN || !host_drv_oe) ? 16'h0000 : lo_q + 16'h0001;
    end
    always_ff @(posedge SYS_CLK_IN) begin
        ack_q <= (RST_IN || !dev_drv_oe) ? 16'h0000 : ack_q + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_host_od; host_drv_oe |-> !host_drv_o; endproperty
    property p_ack_low; dev_drv_oe |-> !dev_drv_o; endproperty
    property p_ack_hold; $rose(dev_drv_oe) |-> host_drv_oe && $past(host_drv_oe, VAL_CYC); endproperty
    property p_ack_len; $fell(dev_drv_oe) |-> ack_q == ACK_CYC; endproperty
    property p_ack_max; ack_q <= ACK_CYC; endproperty
    property p_no_new; dev_drv_oe |-> !$rose(host_drv_oe); endproperty
    property p_start; $rose(host_drv_oe) |-> hi_q >= BIT_Q - 1; endproperty
    property p_low_len;
        $fell(host_drv_oe) |-> lo_q inside {[BIT_Q-1:BIT_Q+1], [3*BIT_Q-1:3*BIT_Q+1],
            [HOLD_CYC-1:HOLD_CYC+1]};
    endproperty
    a_host_od: assert property (p_host_od) else $error("host drives the wire high");
    a_ack_low: assert property (p_ack_low) else $error("device drives the wire high");
    a_ack_hold: assert property (p_ack_hold) else $error("ack before validity delay");
    a_ack_len: assert property (p_ack_len) else $error("ack pulse length wrong");
    a_ack_max: assert property (p_ack_max) else $error("ack pulse too long");
    a_no_new: assert property (p_no_new) else $error("host restarted during ack");
    a_start: assert property (p_start) else $error("start or end interval too short");
    a_low_len: assert property (p_low_len) else $error("host low time off ratio");
    c_ack: cover property ($rose(dev_drv_oe));
    c_long_low: cover property ($fell(host_drv_oe) && lo_q > 2 * BIT_Q);
    c_idle_start: cover property ($rose(host_drv_oe) && hi_q > 2 * BIT_Q);
endmodule
`default_nettype wire

// File: test_one_wire_brightness_link.sv
// Purpose: host driven over APB, a second device from a raw wire
// Assumes: shortened ack and shutdown counts
// Notes: the raw link sends what the host never would
`timescale 1ns/100ps
`default_nettype none
module test_one_wire_brightness_link;
    import owb_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, ok, bad, ok_b, bad_b, sd_b, ack_p;
    logic [4:0] lvl, lvl_b;
    int error_cnt = 0, n_compared = 0;
    int n_ok = 0, n_bad = 0, n_okb = 0, n_badb = 0, n_ack = 0;
    owb_link_if lk ();
    owb_link_if lk_b ();
    assign lk_b.host_drv_o = 1'b0;
    owb_host i_owb_host (.SYS_CLK_IN(clk), .RST_IN(rst),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .LINK(lk.host_end));
    owb_dev #(.ACK_CYC(400)) i_owb_dev (.SYS_CLK_IN(clk),
        .RST_IN(rst), .LINK(lk.device_end), .LEVEL_OUT(lvl), .SHUTDOWN_OUT(),
        .FRAME_OK_OUT(ok), .FRAME_BAD_OUT(bad));
    owb_dev #(.SD_CYC(3000)) i_owb_dev_b (.SYS_CLK_IN(clk),
        .RST_IN(rst), .LINK(lk_b.device_end), .LEVEL_OUT(lvl_b), .SHUTDOWN_OUT(sd_b),
        .FRAME_OK_OUT(ok_b), .FRAME_BAD_OUT(bad_b));
    owb_link_chk #(.ACK_CYC(400)) i_owb_link_chk (
        .SYS_CLK_IN(clk), .RST_IN(rst), .host_drv_o(lk.host_drv_o),
        .host_drv_oe(lk.host_drv_oe), .dev_drv_o(lk.dev_drv_o),
        .dev_drv_oe(lk.dev_drv_oe), .ctrl_line(lk.ctrl_line));
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // count pulses so none is missed
    always @(posedge clk) begin
        n_ok += (ok === 1'b1);
        n_bad += (bad === 1'b1);
        n_okb += (ok_b === 1'b1);
        n_badb += (bad_b === 1'b1);
        n_ack += (lk.dev_drv_oe === 1'b1 && ack_p !== 1'b1);
        ack_p = lk.dev_drv_oe;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) error_cnt++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task host_frame(input logic [7:0] db, input logic [4:0] lv, input logic ak,
                    input logic good);
        int s_ok, s_bad, s_ack, i;
        logic [31:0] r;
        logic e;
        s_ok = n_ok;
        s_bad = n_bad;
        s_ack = n_ack;
        apb(1'b1, REG_CMD_OFS, 32'h0000_0100 | 32'(db), r, e);
        apb(1'b0, REG_CMD_OFS, 32'h0000_0000, r, e);
        chk("cmd", r, 32'(db));
        i = 0;
        do begin
            apb(1'b0, REG_STAT_OFS, 32'h0000_0000, r, e);
            i++;
        end while (r[STAT_DONE_POS] !== 1'b1 && i < 3000);
        chk("done", 32'(r[STAT_DONE_POS]), 32'h0000_0001);
        for (i = 0; i < 100 && n_ok + n_bad == s_ok + s_bad; i++) @(posedge clk);
        chk("level", 32'(lvl), 32'(lv));
        chk("frame ok", 32'(n_ok - s_ok), 32'(good));
        chk("frame bad", 32'(n_bad - s_bad), 32'(!good));
        chk("ack pulses", 32'(n_ack - s_ack), 32'(ak));
        chk("ack seen", 32'(r[STAT_ACK_POS]), 32'(ak));
    endtask
    // one: low 80 high 240; zero: reverse; 160 high ends byte
    task byte_b(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            lk_b.host_drv_oe <= 1'b1;
            repeat (b[i] ? 80 : 240) @(posedge clk);
            lk_b.host_drv_oe <= 1'b0;
            repeat (b[i] ? 240 : 80) @(posedge clk);
        end
        repeat (160) @(posedge clk);
    endtask
    task raw_frame(input logic [7:0] a, input logic [7:0] d, input logic [4:0] lv,
                   input logic good);
        int s_ok, s_bad, i;
        s_ok = n_okb;
        s_bad = n_badb;
        byte_b(a);
        byte_b(d);
        for (i = 0; i < 100 && n_okb + n_badb == s_ok + s_bad; i++) @(posedge clk);
        chk("raw level", 32'(lvl_b), 32'(lv));
        chk("raw ok", 32'(n_okb - s_ok), 32'(good));
        chk("raw bad", 32'(n_badb - s_bad), 32'(!good));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        logic [31:0] r;
        logic e;
        chk("reset level", 32'(lvl), 32'(LEVEL_DEFAULT));
        apb(1'b0, REG_STAT_OFS, 32'h0000_0000, r, e);
        chk("reset status", r, 32'h0000_0000);
        apb(1'b0, 8'h08, 32'h0000_0000, r, e);
        chk("unmapped err", 32'(e), 32'h0000_0001);
        chk("unmapped data", r, 32'h0000_0000);
    endtask
    task t_host;
        host_frame(8'h0a, 5'h0a, 1'b0, 1'b1);
        host_frame(8'h95, 5'h15, 1'b1, 1'b1);
        host_frame(8'h80, 5'h00, 1'b1, 1'b1);
        host_frame(8'ha3, 5'h00, 1'b0, 1'b0);
    endtask
    task t_raw;
        raw_frame(8'h73, 8'h0a, 5'h1f, 1'b0);
        raw_frame(8'h72, 8'h0a, 5'h0a, 1'b1);
        lk_b.host_drv_oe <= 1'b1;
        repeat (2900) @(posedge clk);
        chk("no shutdown yet", 32'(sd_b), 32'h0000_0000);
        repeat (200) @(posedge clk);
        chk("shutdown", 32'(sd_b), 32'h0000_0001);
        chk("shutdown level", 32'(lvl_b), 32'(LEVEL_DEFAULT));
        lk_b.host_drv_oe <= 1'b0;
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        lk_b.host_drv_oe = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset;
        t_host;
        t_raw;
        test_done;
    end
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        test_done;
    end
endmodule
`default_nettype wire
